//--- hdl/lbs_sequencer.sv
// Purpose: start-up order of buck, negative pump, isolation switch,
//          boost converter and positive pump for an lcd bias supply
// Assumes: all inputs are comparator flags synchronous to CORE_CLK
// Notes:   analogue levels appear only as flags
`timescale 1ns/1ps
module lbs_sequencer #(
    parameter int RST_CYC   = lbs_pkg::RST_CYCLES,
    parameter int DLY_CYC   = lbs_pkg::DLY_CYCLES,
    parameter int CHECK_CYC = lbs_pkg::CHECK_CYCLES,
    parameter int STEP_CYC  = lbs_pkg::SOFT_STEP_CYC
) (
    // clock and reset
    input  wire logic                      CORE_CLK,
    input  wire logic                      RST_N,
    // supply monitors
    input  wire logic                      INPUT_LOCKOUT,
    input  wire logic                      THERMAL_HOT,
    input  wire logic                      THERMAL_COOL,
    input  wire logic                      BUCK_POWER_GOOD,
    input  wire logic                      BOOST_RAIL_AT_VIN,
    input  wire logic                      POS_FEEDBACK_100MV,
    input  wire logic                      BOOST_SWITCHING,
    // external enable mode on reset_timing_pin
    input  wire logic                      EXT_ENABLE_MODE,
    input  wire logic                      RESET_TIMING_PIN,
    // converter enables
    output logic                           BUCK_EN,
    output logic                           NEG_PUMP_EN,
    output logic                           BOOST_EN,
    output logic                           POS_PUMP_SC_MODE,
    output logic                           POS_PUMP_REGULATE,
    output logic [lbs_pkg::SOFT_W-1:0]     POSITIVE_PUMP_CONTROL,
    // isolation gate, active low
    output logic                           ISOLATION_GATE_DRIVE_N,
    // open-drain reset to timing controller
    output logic                           TCON_RESET_O,
    output logic                           TCON_RESET_OE_N,
    // status
    output logic                           BOOST_START_ERROR,
    output logic                           THERMAL_SHUTDOWN
);
    lbs_pkg::lbs_state_t state_reg;
    lbs_pkg::lbs_state_t state_next;
    logic [lbs_pkg::CNT_W-1:0]  cnt_reg;
    logic [lbs_pkg::CNT_W-1:0]  step_reg;
    logic [lbs_pkg::SOFT_W-1:0] soft_reg;
    logic                       hot_reg;
    logic                       error_reg;
    logic                       pump_held_reg;
    logic                       inhibit;
    logic                       cnt_done;

    assign inhibit  = INPUT_LOCKOUT | hot_reg;
    assign cnt_done = (cnt_reg == '0);

    always_ff @(posedge CORE_CLK or negedge RST_N)
    begin
        if (!RST_N)
            hot_reg <= 1'b0;
        else if (THERMAL_HOT)
            hot_reg <= 1'b1;
        else if (THERMAL_COOL)
            hot_reg <= 1'b0;
    end

    always_comb
    begin
        state_next = state_reg;
        unique case (state_reg)
            lbs_pkg::LBS_OFF:
                state_next = lbs_pkg::LBS_BUCK;
            lbs_pkg::LBS_BUCK:
                if (BUCK_POWER_GOOD)
                    state_next = EXT_ENABLE_MODE ? lbs_pkg::LBS_WAIT_EN
                                                 : lbs_pkg::LBS_RESET;
            lbs_pkg::LBS_RESET:
                // only the timer, not the pin
                if (cnt_done)
                    state_next = lbs_pkg::LBS_DELAY;
            lbs_pkg::LBS_WAIT_EN:
                if (RESET_TIMING_PIN)
                    state_next = lbs_pkg::LBS_DELAY;
            lbs_pkg::LBS_DELAY:
                if (cnt_done)
                    state_next = lbs_pkg::LBS_CHECK;
            lbs_pkg::LBS_CHECK:
                // single sample at 1 ms; miss is an error
                if (cnt_done)
                    state_next = BOOST_RAIL_AT_VIN ? lbs_pkg::LBS_RUN
                                                   : lbs_pkg::LBS_FAULT;
            lbs_pkg::LBS_RUN:
                state_next = lbs_pkg::LBS_RUN;
            lbs_pkg::LBS_FAULT:
                state_next = lbs_pkg::LBS_FAULT;
            default:
                state_next = lbs_pkg::LBS_OFF;
        endcase
    end

    // any shutdown restarts; enables drop together, pump control with them, or one cycle later in regulation
    always_ff @(posedge CORE_CLK or negedge RST_N)
    begin
        if (!RST_N)
            state_reg <= lbs_pkg::LBS_OFF;
        else if (inhibit)
            state_reg <= lbs_pkg::LBS_OFF;
        else
            state_reg <= state_next;
    end

    // one down-counter shared by reset, delay and check phases
    always_ff @(posedge CORE_CLK or negedge RST_N)
    begin
        if (!RST_N)
            cnt_reg <= '0;
        else if (state_next != state_reg || inhibit)
        begin
            unique case (state_next)
                // zero reset time falls through at once
                lbs_pkg::LBS_RESET:
                    cnt_reg <= (RST_CYC > 0) ?
                        lbs_pkg::CNT_W'(RST_CYC - 1) : '0;
                lbs_pkg::LBS_DELAY:
                    cnt_reg <= lbs_pkg::CNT_W'(DLY_CYC - 1);
                lbs_pkg::LBS_CHECK:
                    cnt_reg <= lbs_pkg::CNT_W'(CHECK_CYC - 1);
                default:
                    cnt_reg <= '0;
            endcase
        end
        else if (!cnt_done)
            cnt_reg <= cnt_reg - 1'b1;
    end

    always_ff @(posedge CORE_CLK or negedge RST_N)
    begin
        if (!RST_N)
            error_reg <= 1'b0;
        else if (state_next == lbs_pkg::LBS_FAULT)
            error_reg <= 1'b1;
        else if (state_reg == lbs_pkg::LBS_OFF && !inhibit)
            error_reg <= 1'b0;
    end

    // pause pump current once feedback seen
    always_ff @(posedge CORE_CLK or negedge RST_N)
    begin
        if (!RST_N)
            pump_held_reg <= 1'b0;
        else if (state_reg != lbs_pkg::LBS_CHECK &&
                 state_reg != lbs_pkg::LBS_RUN)
            pump_held_reg <= 1'b0;
        else if (POS_FEEDBACK_100MV)
            pump_held_reg <= 1'b1;
    end

    // soft start ramp, one step per STEP_CYC clocks
    always_ff @(posedge CORE_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            step_reg <= '0;
            soft_reg <= lbs_pkg::SOFT_ZERO;
        end
        else if (!POS_PUMP_REGULATE)
        begin
            step_reg <= '0;
            soft_reg <= lbs_pkg::SOFT_ZERO;
        end
        else if (step_reg == lbs_pkg::CNT_W'(STEP_CYC - 1))
        begin
            step_reg <= '0;
            if (soft_reg != lbs_pkg::SOFT_FULL)
                soft_reg <= soft_reg + 1'b1;
        end
        else
            step_reg <= step_reg + 1'b1;
    end

    logic gate_on;
    logic sc_mode;
    assign gate_on = (state_reg == lbs_pkg::LBS_CHECK) ||
                     (state_reg == lbs_pkg::LBS_RUN);
    assign sc_mode = gate_on && !(state_reg == lbs_pkg::LBS_RUN &&
                                  BOOST_SWITCHING);

    always_ff @(posedge CORE_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            BUCK_EN                <= 1'b0;
            NEG_PUMP_EN            <= 1'b0;
            BOOST_EN               <= 1'b0;
            POS_PUMP_SC_MODE       <= 1'b0;
            POS_PUMP_REGULATE      <= 1'b0;
            POSITIVE_PUMP_CONTROL  <= lbs_pkg::SOFT_ZERO;
            ISOLATION_GATE_DRIVE_N <= 1'b1;
            TCON_RESET_OE_N        <= 1'b0;
        end
        else
        begin
            BUCK_EN <= state_reg != lbs_pkg::LBS_OFF;
            // negative pump waits for reset time or enable pin; with release
            NEG_PUMP_EN <= state_reg == lbs_pkg::LBS_DELAY || gate_on ||
                           state_reg == lbs_pkg::LBS_FAULT;
            // boost only after reset and check
            BOOST_EN <= state_reg == lbs_pkg::LBS_RUN;
            // gate low for the isolation switch
            ISOLATION_GATE_DRIVE_N <= !(gate_on ||
                                        state_reg == lbs_pkg::LBS_FAULT);
            POS_PUMP_SC_MODE <= sc_mode;
            POS_PUMP_REGULATE <= state_reg == lbs_pkg::LBS_RUN &&
                                 BOOST_SWITCHING;
            // full in short mode until feedback, then zero; ramp in regulation
            if (POS_PUMP_REGULATE)
                POSITIVE_PUMP_CONTROL <= soft_reg;
            else if (sc_mode && !pump_held_reg)
                POSITIVE_PUMP_CONTROL <= lbs_pkg::SOFT_FULL;
            else
                POSITIVE_PUMP_CONTROL <= lbs_pkg::SOFT_ZERO;
            // pull low only, released after reset time, or after the pin in external enable mode
            TCON_RESET_OE_N <= state_reg == lbs_pkg::LBS_DELAY || gate_on ||
                               state_reg == lbs_pkg::LBS_FAULT;
        end
    end

    // open drain: output level is always low
    assign TCON_RESET_O      = 1'b0;
    assign BOOST_START_ERROR = error_reg;
    assign THERMAL_SHUTDOWN  = hot_reg;
endmodule : lbs_sequencer

//--- include/lbs_pkg.sv
// Purpose: shared constants for the lcd bias start-up sequencer
// Assumes: 125 MHz core clock
// Notes:   times are kept in their own unit, counts derived from them
package lbs_pkg;
    localparam int CLK_MHZ        = 125;
    localparam int CHECK_TIME_US  = 1000;
    localparam int CHECK_CYCLES   = CHECK_TIME_US * CLK_MHZ;
    localparam int RST_TIME_US    = 1000;
    localparam int RST_CYCLES     = RST_TIME_US * CLK_MHZ;
    localparam int DLY_TIME_US    = 1000;
    localparam int DLY_CYCLES     = DLY_TIME_US * CLK_MHZ;
    localparam int SOFT_STEP_US   = 1;
    localparam int SOFT_STEP_CYC  = SOFT_STEP_US * CLK_MHZ;
    localparam int CNT_W          = 32;
    localparam int SOFT_W         = 8;
    localparam logic [SOFT_W-1:0] SOFT_FULL = 8'hff;
    localparam logic [SOFT_W-1:0] SOFT_ZERO = 8'h00;

    typedef enum logic [2:0] {
        LBS_OFF,
        LBS_BUCK,
        LBS_RESET,
        LBS_WAIT_EN,
        LBS_DELAY,
        LBS_CHECK,
        LBS_RUN,
        LBS_FAULT
    } lbs_state_t;
endpackage : lbs_pkg

//--- tb/lbs_tcon_model.sv
// Purpose: timing controller side of the open-drain reset line
// Assumes: pull-up on the wire, device only ever pulls low
// Notes:   rst_wire mirrors what the controller would see
`timescale 1ns/1ps
module lbs_tcon_model (
    // device pins
    input  wire logic rst_o,
    input  wire logic rst_oe_n,
    // resolved wire
    output wire logic rst_wire
);
    assign rst_wire = rst_oe_n ? 1'b1 : rst_o;
endmodule : lbs_tcon_model

//--- tb/lbs_seq_sva.sv
// Purpose: port-level checks of the start-up order
// Assumes: bench keeps inhibits away from the timed windows
// Notes:   windows allow two cycles of registering slack
`timescale 1ns/1ps
module lbs_seq_sva #(
    parameter int DLY_CYC   = 20,
    parameter int CHECK_CYC = 30
) (
    input wire logic       CORE_CLK,
    input wire logic       RST_N,
    input wire logic       INPUT_LOCKOUT,
    input wire logic       EXT_ENABLE_MODE,
    input wire logic       BUCK_EN,
    input wire logic       NEG_PUMP_EN,
    input wire logic       BOOST_EN,
    input wire logic       POS_PUMP_SC_MODE,
    input wire logic       POS_PUMP_REGULATE,
    input wire logic [7:0] POSITIVE_PUMP_CONTROL,
    input wire logic       ISOLATION_GATE_DRIVE_N,
    input wire logic       TCON_RESET_O,
    input wire logic       TCON_RESET_OE_N,
    input wire logic       BOOST_START_ERROR
);
    localparam int D_LO = DLY_CYC - 2;
    localparam int D_HI = DLY_CYC + 2;
    localparam int C_LO = CHECK_CYC - 2;
    localparam int C_HI = CHECK_CYC + 2;
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!RST_N);
    property p_off;
        INPUT_LOCKOUT[*3] |-> !(BUCK_EN | NEG_PUMP_EN | BOOST_EN)
            && ISOLATION_GATE_DRIVE_N;
    endproperty
    a_off: assert property (p_off) else $error("outputs on in lockout");
    property p_rel;
        $rose(TCON_RESET_OE_N) |-> NEG_PUMP_EN;
    endproperty
    a_rel: assert property (p_rel) else $error("release without pump");
    property p_dly;
        $rose(NEG_PUMP_EN) |-> ##[D_LO:D_HI] $fell(ISOLATION_GATE_DRIVE_N);
    endproperty
    a_dly: assert property (p_dly) else $error("gate delay wrong");
    property p_sc;
        $fell(ISOLATION_GATE_DRIVE_N) |-> POS_PUMP_SC_MODE && !BOOST_EN;
    endproperty
    a_sc: assert property (p_sc) else $error("no short mode at gate");
    property p_chk;
        $fell(ISOLATION_GATE_DRIVE_N) |->
            ##[C_LO:C_HI] ($rose(BOOST_EN) || $rose(BOOST_START_ERROR));
    endproperty
    a_chk: assert property (p_chk) else $error("rail check time wrong");
    property p_err;
        BOOST_START_ERROR |-> !BOOST_EN;
    endproperty
    a_err: assert property (p_err) else $error("boost on with error");
    property p_rst;
        BOOST_EN && !EXT_ENABLE_MODE |-> TCON_RESET_OE_N && NEG_PUMP_EN;
    endproperty
    a_rst: assert property (p_rst) else $error("boost before reset end");
    property p_reg;
        $rose(POS_PUMP_REGULATE) |-> BOOST_EN && !POS_PUMP_SC_MODE;
    endproperty
    a_reg: assert property (p_reg) else $error("regulation too early");
    property p_ramp;
        POS_PUMP_REGULATE && $past(POS_PUMP_REGULATE) |->
            POSITIVE_PUMP_CONTROL >= $past(POSITIVE_PUMP_CONTROL);
    endproperty
    a_ramp: assert property (p_ramp) else $error("soft start fell");
    property p_od;
        BUCK_EN |-> !TCON_RESET_O;
    endproperty
    a_od: assert property (p_od) else $error("reset drives high");
    c_run: cover property ($rose(BOOST_EN));
    c_err: cover property ($rose(BOOST_START_ERROR));
    c_reg: cover property ($rose(POS_PUMP_REGULATE));
endmodule : lbs_seq_sva
bind lbs_sequencer lbs_seq_sva #(.DLY_CYC(DLY_CYC), .CHECK_CYC(CHECK_CYC))
    u_sva (.*);

//--- tb/tb_top.sv
// Purpose: scenario bench for the bias start-up sequencer
// Assumes: short counts 20/20/30/4 instead of the long defaults
// Notes:   outputs are sampled on the falling edge
`timescale 1ns/1ps
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin \
    num_errors++; $display("CHECK FAILED t=%0t got=%h exp=%h", \
    $time, (a), (e)); end end
module tb_top;
    logic       clk, rst_n, lko, hot, cool, pg, rail, fb, sw, extm, pin;
    logic       buck, neg, boost, sc, reg_on, gate_n, ro, roe_n, err, tsd;
    logic [7:0] ctrl, c1;
    wire        tcon_rst;
    int         num_errors, samples_checked;
    lbs_sequencer #(.RST_CYC(20), .DLY_CYC(20), .CHECK_CYC(30),
        .STEP_CYC(4)) u_dut (.CORE_CLK(clk), .RST_N(rst_n),
        .INPUT_LOCKOUT(lko), .THERMAL_HOT(hot), .THERMAL_COOL(cool),
        .BUCK_POWER_GOOD(pg), .BOOST_RAIL_AT_VIN(rail),
        .POS_FEEDBACK_100MV(fb), .BOOST_SWITCHING(sw),
        .EXT_ENABLE_MODE(extm), .RESET_TIMING_PIN(pin), .BUCK_EN(buck),
        .NEG_PUMP_EN(neg), .BOOST_EN(boost), .POS_PUMP_SC_MODE(sc),
        .POS_PUMP_REGULATE(reg_on), .POSITIVE_PUMP_CONTROL(ctrl),
        .ISOLATION_GATE_DRIVE_N(gate_n), .TCON_RESET_O(ro),
        .TCON_RESET_OE_N(roe_n), .BOOST_START_ERROR(err),
        .THERMAL_SHUTDOWN(tsd));
    lbs_tcon_model u_tcon (.rst_o(ro), .rst_oe_n(roe_n),
        .rst_wire(tcon_rst));
    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    function automatic logic sig(input int k);
        return k == 0 ? buck : k == 1 ? neg : k == 2 ? gate_n :
            k == 3 ? boost : k == 4 ? err : reg_on;
    endfunction : sig
    // bounded wait for one output level, then judged
    task automatic wt(input int k, input logic v);
        int n;
        n = 0;
        while (sig(k) !== v && n < 200)
        begin
            @(negedge clk);
            n++;
        end
        `CHK(sig(k), v)
    endtask : wt
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask : cyc
    task automatic go_off();
        @(posedge clk);
        lko <= 1'b1; pg <= 1'b0; rail <= 1'b0; fb <= 1'b0; sw <= 1'b0;
        cyc(3);
        `CHK({buck, neg, boost, gate_n, tcon_rst}, 5'h02)
    endtask : go_off
    task automatic t_start();
        @(posedge clk);
        lko <= 1'b0; pg <= 1'b1;
        wt(0, 1'b1);
        `CHK(tcon_rst, 1'b0)
        wt(1, 1'b1);
        `CHK({roe_n, tcon_rst}, 2'h3)
    endtask : t_start
    task automatic t_run();
        wt(2, 1'b0);
        `CHK(sc, 1'b1)
        @(posedge clk) fb <= 1'b1;
        cyc(4);
        `CHK(ctrl, lbs_pkg::SOFT_ZERO)
        @(posedge clk) rail <= 1'b1;
        wt(3, 1'b1);
        @(posedge clk) sw <= 1'b1;
        wt(5, 1'b1);
        `CHK(sc, 1'b0)
        c1 = ctrl;
        cyc(12);
        `CHK(ctrl > c1, 1'b1)
    endtask : t_run
    task automatic t_fault();
        t_start();
        wt(2, 1'b0);
        wt(4, 1'b1);
        cyc(20);
        `CHK({err, boost}, 2'h2)
        go_off();
        // the error stays up through lockout until the restart from off
        `CHK(err, 1'b1)
    endtask : t_fault
    task automatic t_ext();
        @(posedge clk);
        extm <= 1'b1; pin <= 1'b0; lko <= 1'b0; pg <= 1'b1;
        cyc(80);
        `CHK({buck, neg}, 2'h2)
        `CHK(err, 1'b0)
        @(posedge clk) pin <= 1'b1;
        wt(1, 1'b1);
        wt(2, 1'b0);
        // let the rail check finish before lockout cuts the sequence
        wt(4, 1'b1);
        go_off();
        @(posedge clk) extm <= 1'b0;
    endtask : t_ext
    task automatic t_hot();
        t_start();
        // keep the shutdown out of the delay and check windows
        wt(2, 1'b0);
        wt(4, 1'b1);
        @(posedge clk);
        hot <= 1'b1; cool <= 1'b0;
        // flag, then state, then outputs: one edge more than lockout
        cyc(4);
        `CHK({tsd, buck, neg}, 3'h4)
        @(posedge clk) hot <= 1'b0;
        cyc(5);
        `CHK(buck, 1'b0)
        @(posedge clk) cool <= 1'b1;
        wt(1, 1'b1);
    endtask : t_hot
    task automatic complete_run();
        if (num_errors == 0 && samples_checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : complete_run
    initial
    begin
        num_errors = 0; samples_checked = 0; rst_n = 1'b0; lko = 1'b1;
        {hot, pg, rail, fb, sw, extm, pin} = 7'h00; cool = 1'b1;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        t_start(); t_run(); go_off();
        t_start(); t_run(); go_off();
        t_fault(); t_ext(); t_hot();
        complete_run();
    end
    initial
    begin
        repeat (20000) @(posedge clk);
        num_errors++;
        complete_run();
    end
endmodule : tb_top
